// [rtl/reiu_regs.svh]
`ifndef REIU_REGS_SVH
`define REIU_REGS_SVH
`define REIU_ADDR_W 7
`define REIU_OFS_STATUS_A 7'h03
`define REIU_OFS_STATUS_B 7'h04
`define REIU_OFS_ENABLE_A 7'h05
`define REIU_OFS_ENABLE_B 7'h06
`define REIU_RST_ENABLE_A 8'h00
`define REIU_RST_ENABLE_B 8'h01
`define REIU_RST_STATUS 8'h00
`define REIU_RD_UNMAPPED 8'h00
`define REIU_BIT_A_FIFO_ERR 7
`define REIU_BIT_A_TX_AFULL 6
`define REIU_BIT_A_TX_AEMPTY 5
`define REIU_BIT_A_RX_AFULL 4
`define REIU_BIT_A_EXT 3
`define REIU_BIT_A_PKT_SENT 2
`define REIU_BIT_A_PKT_VALID 1
`define REIU_BIT_A_CRC_ERR 0
`define REIU_BIT_B_SYNC_DET 7
`define REIU_BIT_B_PRE_VALID 6
`define REIU_BIT_B_PRE_INVALID 5
`define REIU_BIT_B_RSSI 4
`define REIU_BIT_B_WUT 3
`define REIU_BIT_B_LOW_BATT 2
`define REIU_BIT_B_CHIP_RDY 1
`define REIU_BIT_B_POR 0
`endif

// [rtl/reiu_pkg.sv]
package reiu_pkg;
    // first event group, bit 7 down to bit 0
    typedef struct packed {
        logic fifo_err;
        logic tx_afull;
        logic tx_aempty;
        logic rx_afull;
        logic ext;
        logic pkt_sent;
        logic pkt_valid;
        logic crc_err;
    } reiu_events_a_t;
    // second event group, bit 7 down to bit 0
    typedef struct packed {
        logic sync_det;
        logic pre_valid;
        logic pre_invalid;
        logic rssi;
        logic wut;
        logic low_batt;
        logic chip_rdy;
        logic por;
    } reiu_events_b_t;
    // register port request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reiu_req_t;
endpackage

// [rtl/reiu_radio_event_interrupt_unit.sv]
`include "reiu_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module reiu_radio_event_interrupt_unit (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // event pulses or levels from internal logic, same clock
    input wire reiu_pkg::reiu_events_a_t events_a,
    input wire reiu_pkg::reiu_events_b_t events_b,
    // register port
    input wire reiu_pkg::reiu_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // interrupt pin toward host, active low
    output logic event_request_pin_n
);
    logic [7:0] status_a_r;
    logic [7:0] status_b_r;
    logic [7:0] enable_a_r;
    logic [7:0] enable_b_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic irq_n_r;
    logic [7:0] status_a_nxt;
    logic [7:0] status_b_nxt;
    logic [7:0] rd_mux;
    logic [7:0] enable_a_nxt;
    logic [7:0] enable_b_nxt;
    wire sel_sa = req.addr == `REIU_OFS_STATUS_A;
    wire sel_sb = req.addr == `REIU_OFS_STATUS_B;
    wire sel_ea = req.addr == `REIU_OFS_ENABLE_A;
    wire sel_eb = req.addr == `REIU_OFS_ENABLE_B;
    wire rd_sa = req.rd && sel_sa;
    wire rd_sb = req.rd && sel_sb;
    wire wr_ea = req.wr && sel_ea;
    wire wr_eb = req.wr && sel_eb;
    wire [7:0] ev_a = events_a;
    wire [7:0] ev_b = events_b;

    // read clears enabled flags, new event wins
    assign status_a_nxt = (status_a_r & ~(rd_sa ? enable_a_r : 8'h00)) | ev_a;
    assign status_b_nxt = (status_b_r & ~(rd_sb ? enable_b_r : 8'h00)) | ev_b;

    assign rd_mux = sel_sa ? status_a_r :
                    sel_sb ? status_b_r :
                    sel_ea ? enable_a_r :
                    sel_eb ? enable_b_r : `REIU_RD_UNMAPPED;

    // enable values after this edge, so an enable write moves the pin on the same edge
    assign enable_a_nxt = wr_ea ? req.wdata : enable_a_r;
    assign enable_b_nxt = wr_eb ? req.wdata : enable_b_r;

    // pin low when an enabled flag is pending
    wire pend_nxt = |(status_a_nxt & enable_a_nxt) || |(status_b_nxt & enable_b_nxt);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            status_a_r <= `REIU_RST_STATUS;
            status_b_r <= `REIU_RST_STATUS;
        end else begin
            status_a_r <= status_a_nxt;
            status_b_r <= status_b_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            enable_a_r <= `REIU_RST_ENABLE_A;
            enable_b_r <= `REIU_RST_ENABLE_B;
        end else begin
            if (wr_ea) begin
                enable_a_r <= req.wdata;
            end
            if (wr_eb) begin
                enable_b_r <= req.wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= req.rd;
            if (req.rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // pin follows pending enabled flags; released once read clears them
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= ~pend_nxt;
        end
    end

    assign rdata = rdata_r;
    assign rvalid = rvalid_r;
    assign event_request_pin_n = irq_n_r;
endmodule
`default_nettype wire

// [sim/reiu_chk_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module reiu_chk (
    // design ports
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire reiu_pkg::reiu_events_a_t events_a,
    input wire reiu_pkg::reiu_events_b_t events_b,
    input wire reiu_pkg::reiu_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic event_request_pin_n
);
    wire logic lo = !event_request_pin_n;
    wire logic ev = |{events_a, events_b};
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_rb; req.rd && req.addr == 7'h04 && !ev; endsequence
    property p_rv; req.rd |=> rvalid; endproperty
    a_rv: assert property (p_rv) else $error("rvalid missing");
    property p_nv; !req.rd |=> !rvalid; endproperty
    a_nv: assert property (p_nv) else $error("stray rvalid");
    property p_hd; lo && !req.rd && !req.wr |=> lo; endproperty
    a_hd: assert property (p_hd) else $error("pin released early");
    property p_qt; !lo && !req.wr && !ev |=> !lo; endproperty
    a_qt: assert property (p_qt) else $error("pin low without event");
    property p_cs; $rose(lo) |-> $past(ev) || $past(req.wr); endproperty
    a_cs: assert property (p_cs) else $error("pin fell without cause");
    property p_rs; $fell(sys_rst) |-> !lo && !rvalid; endproperty
    a_rs: assert property (p_rs) else $error("bad state after reset");
    property p_st; !req.rd |=> $stable(rdata); endproperty
    a_st: assert property (p_st) else $error("rdata moved");
    property p_cl; s_rb ##1 !ev ##1 s_rb |=> (rdata & ~$past(rdata, 2)) == 8'h00; endproperty
    a_cl: assert property (p_cl) else $error("read set a flag");
endmodule
bind reiu_radio_event_interrupt_unit reiu_chk reiu_chk_i (.core_clk, .sys_rst, .events_a,
    .events_b, .req, .rdata, .rvalid, .event_request_pin_n);
`default_nettype wire

// [sim/reiu_host.sv]
`timescale 1ns/1ps
`default_nettype none
module reiu_host (
    // register port
    input wire logic core_clk,
    output var reiu_pkg::reiu_req_t req
);
    initial req = '0;
    // request held for one taking edge, then one idle cycle for the answer
    task automatic acc(input logic r, input logic [6:0] a, input logic [7:0] w);
        req <= '{r, !r, a, w};
        @(posedge core_clk);
        req <= '0;
        @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk = 1'b0, sys_rst = 1'b1;
    logic [15:0] ev = 16'h0000;
    reiu_pkg::reiu_req_t req;
    logic [7:0] rdata;
    logic rvalid, pin_n;
    int err_count = 0, cmp_count = 0;
    always #4 core_clk = ~core_clk;
    reiu_radio_event_interrupt_unit reiu_radio_event_interrupt_unit_i (.core_clk, .sys_rst,
        .events_a(ev[15:8]), .events_b(ev[7:0]), .req, .rdata, .rvalid,
        .event_request_pin_n(pin_n));
    reiu_host reiu_host_i (.core_clk, .req);
    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // read, then compare read data and pin level together
    task automatic rd(input logic [6:0] a, input logic [8:0] e);
        reiu_host_i.acc(1'b1, a, 8'h00);
        // look between edges so the registered answer has settled
        @(negedge core_clk);
        cmp_count++;
        err_count += int'({rdata, pin_n} !== e);
        if ({rdata, pin_n} !== e)
            $display("[FAIL] rdata_pin exp %h got %h", e, {rdata, pin_n});
        @(posedge core_clk);
    endtask
    initial begin
        #4000 err_count++;
        results;
    end
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(7'h05, 9'h001);
        rd(7'h06, 9'h003);
        rd(7'h07, 9'h001);
        ev <= 16'hFFFF;
        @(posedge core_clk);
        ev <= 16'h0000;
        rd(7'h03, 9'h1FE);
        rd(7'h04, 9'h1FF);
        rd(7'h04, 9'h1FD);
        $display("masked events done");
        reiu_host_i.acc(1'b0, 7'h05, 8'hFF);
        reiu_host_i.acc(1'b0, 7'h06, 8'hFF);
        rd(7'h03, 9'h1FE);
        rd(7'h04, 9'h1FD);
        for (int i = 0; i < 16; i++) begin
            ev <= 16'h0001 << i;
            @(posedge core_clk);
            ev <= 16'h0000;
            rd(i < 8 ? 7'h03 : 7'h04, 9'h000);
            rd(i < 8 ? 7'h04 : 7'h03, {8'h01 << (i % 8), 1'b1});
        end
        $display("enabled events done");
        // event lands on the same edge as the clearing read
        ev <= 16'h0100;
        fork
            rd(7'h03, 9'h000);
            begin
                @(posedge core_clk);
                ev <= 16'h0000;
            end
        join
        rd(7'h03, 9'h003);
        $display("read collision done");
        results;
    end
endmodule
`default_nettype wire
